// file: dsp_timer.sv
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/10ps
module dsp_timer (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	// axi4-lite write address
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [dsp_pkg::ADDR_W-1:0] i_awaddr,
	input wire logic [2:0] i_awprot,
	// axi4-lite write data
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [dsp_pkg::DATA_W-1:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	// axi4-lite write response
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	// axi4-lite read address
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [dsp_pkg::ADDR_W-1:0] i_araddr,
	input wire logic [2:0] i_arprot,
	// axi4-lite read data
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [dsp_pkg::DATA_W-1:0] o_rdata,
	output logic [1:0] o_rresp,
	// ordinary port data when the compare output is disconnected
	input wire logic i_port_data_a,
	input wire logic i_port_data_b,
	// compare output pins
	output logic o_pin_a,
	output logic o_pin_a_oe_b,
	output logic o_pin_b,
	output logic o_pin_b_oe_b
);
	import dsp_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_reg;
	logic rst_b;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [DATA_W-1:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic do_write;
	logic [DATA_W-1:0] ctrl_reg;
	logic [CNT_W-1:0] count_value_reg;
	logic count_up_reg;
	logic [CNT_W-1:0] capture_value_reg;
	logic [FLG_W-1:0] flags_reg;
	logic [FLG_W-1:0] flag_set;
	logic [FLG_W-1:0] flag_clr;
	logic [3:0] waveform_select;
	dsp_action_type output_action_select_a;
	dsp_action_type output_action_select_b;
	logic pin_direction_bit_a;
	logic pin_direction_bit_b;
	logic tick;
	logic run_tick;
	logic [CNT_W-1:0] top_value;
	logic at_top;
	logic at_bottom;
	logic dir_up_eff;
	logic toggle_ok_a;
	logic conn_a;
	logic conn_b;
	logic wr_ctrl;
	logic wr_count;
	logic wr_cmp_a;
	logic wr_cmp_b;
	logic wr_capt;
	logic wr_flags;
	logic [DATA_W-1:0] wr_merge_cnt;
	logic [DATA_W-1:0] wr_merge_a;
	logic [DATA_W-1:0] wr_merge_b;
	logic [DATA_W-1:0] wr_merge_capt;
	logic [DATA_W-1:0] wr_merge_ctrl;
	logic [CNT_W-1:0] cmp_a_buffer;
	logic [CNT_W-1:0] cmp_a_active;
	logic [CNT_W-1:0] cmp_b_buffer;
	logic [CNT_W-1:0] cmp_b_active;
	logic match_a;
	logic match_b;
	logic level_a;
	logic level_b;

	dsp_cnt_if cnt_bus ();

	// byte-lane merge of a write onto the old word
	function automatic logic [DATA_W-1:0] merge_strb(
		input logic [DATA_W-1:0] old_word,
		input logic [DATA_W-1:0] new_word,
		input logic [3:0] strb
	);
		logic [DATA_W-1:0] res;
		res = old_word;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = new_word[8*i +: 8];
			end
		end
		merge_strb = res;
	endfunction

	// word-aligned address match
	function automatic logic addr_is(
		input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] offs
	);
		addr_is = (addr[ADDR_W-1:2] == offs[ADDR_W-1:2]);
	endfunction

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
		addr_mapped = addr_is(addr, REG_CTRL) || addr_is(addr, REG_COUNT) ||
			addr_is(addr, REG_CMP_A) || addr_is(addr, REG_CMP_B) ||
			addr_is(addr, REG_CAPT) || addr_is(addr, REG_FLAGS);
	endfunction

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	// assertion is immediate, release waits two clocks
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_b = rst_sync_reg[1];

	// ----------------------------------------------------------------
	// axi4-lite write channel
	// ----------------------------------------------------------------
	// address and data are taken in either order; ready drops until
	// the response is accepted, so one write is in flight at most
	always_ff @(posedge i_core_clk or negedge rst_b) begin
		if (!rst_b) begin
			o_awready <= 1'b1;
			o_wready <= 1'b1;
			o_bvalid <= 1'b0;
			o_bresp <= RESP_OKAY;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else begin
			if (i_awvalid && o_awready) begin
				o_awready <= 1'b0;
				awaddr_reg <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				o_wready <= 1'b0;
				wdata_reg <= i_wdata;
				wstrb_reg <= i_wstrb;
			end
			if (do_write) begin
				o_bvalid <= 1'b1;
				o_bresp <= addr_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
			end else if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
				o_awready <= 1'b1;
				o_wready <= 1'b1;
			end
		end
	end

	assign do_write = !o_awready && !o_wready && !o_bvalid;
	assign wr_ctrl = do_write && addr_is(awaddr_reg, REG_CTRL);
	assign wr_count = do_write && addr_is(awaddr_reg, REG_COUNT);
	assign wr_cmp_a = do_write && addr_is(awaddr_reg, REG_CMP_A);
	assign wr_cmp_b = do_write && addr_is(awaddr_reg, REG_CMP_B);
	assign wr_capt = do_write && addr_is(awaddr_reg, REG_CAPT);
	assign wr_flags = do_write && addr_is(awaddr_reg, REG_FLAGS);

	// merged write words; compare writes lose bits above a fixed TOP
	always_comb begin
		wr_merge_ctrl = merge_strb(ctrl_reg, wdata_reg, wstrb_reg) & CTRL_MASK;
		wr_merge_cnt = merge_strb({16'h0000, count_value_reg}, wdata_reg,
			wstrb_reg);
		wr_merge_a = merge_strb({16'h0000, cmp_a_buffer}, wdata_reg, wstrb_reg) &
			{16'h0000, fixed_mask(waveform_select)};
		wr_merge_b = merge_strb({16'h0000, cmp_b_buffer}, wdata_reg, wstrb_reg) &
			{16'h0000, fixed_mask(waveform_select)};
		wr_merge_capt = merge_strb({16'h0000, capture_value_reg}, wdata_reg,
			wstrb_reg);
	end

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge rst_b) begin
		if (!rst_b) begin
			o_arready <= 1'b1;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b1;
			o_rresp <= addr_mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
			o_rdata <= 32'h0000_0000;
			if (addr_is(i_araddr, REG_CTRL)) begin
				o_rdata <= ctrl_reg;
			end else if (addr_is(i_araddr, REG_COUNT)) begin
				o_rdata <= {16'h0000, count_value_reg};
			end else if (addr_is(i_araddr, REG_CMP_A)) begin
				o_rdata <= {16'h0000, cmp_a_buffer};
			end else if (addr_is(i_araddr, REG_CMP_B)) begin
				o_rdata <= {16'h0000, cmp_b_buffer};
			end else if (addr_is(i_araddr, REG_CAPT)) begin
				o_rdata <= {16'h0000, capture_value_reg};
			end else if (addr_is(i_araddr, REG_FLAGS)) begin
				o_rdata <= {28'h000_0000, flags_reg};
			end
		end else if (o_rvalid && i_rready) begin
			o_rvalid <= 1'b0;
			o_arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_reg <= wr_merge_ctrl;
		end
	end

	// capture value is not double buffered and takes effect at once
	always_ff @(posedge i_core_clk or negedge rst_b) begin
		if (!rst_b) begin
			capture_value_reg <= CNT_RESET;
		end else if (wr_capt) begin
			capture_value_reg <= wr_merge_capt[CNT_W-1:0];
		end
	end

	assign waveform_select = ctrl_reg[CTRL_WGM_LSB +: 4];
	assign output_action_select_a =
		dsp_action_type'(ctrl_reg[CTRL_ACT_A_LSB +: 2]);
	assign output_action_select_b =
		dsp_action_type'(ctrl_reg[CTRL_ACT_B_LSB +: 2]);
	assign pin_direction_bit_a = ctrl_reg[CTRL_DIR_A_BIT];
	assign pin_direction_bit_b = ctrl_reg[CTRL_DIR_B_BIT];

	// ----------------------------------------------------------------
	// timebase
	// ----------------------------------------------------------------
	dsp_prescaler u_prescaler (
		.i_clk(i_core_clk),
		.i_rst_b(rst_b),
		.i_clk_sel(ctrl_reg[CTRL_CS_LSB +: 3]),
		.o_tick(tick)
	);

	// TOP source; compare A in force (not its buffer) defines TOP
	always_comb begin
		case (waveform_select)
			WGM_PC8: top_value = TOP_8;
			WGM_PC9: top_value = TOP_9;
			WGM_PC10: top_value = TOP_10;
			WGM_PC_CAPT: top_value = capture_value_reg;
			WGM_PC_CMPA: top_value = cmp_a_active;
			WGM_PFC_CAPT: top_value = capture_value_reg;
			WGM_PFC_CMPA: top_value = cmp_a_active;
			default: top_value = CNT_MAX;
		endcase
	end

	// other waveform modes are not served here: the counter just halts
	assign run_tick = tick && is_dual(waveform_select);
	assign at_top = (count_value_reg == top_value);
	assign at_bottom = (count_value_reg == BOTTOM);
	// zero turns upward, TOP turns downward; between them keep going
	assign dir_up_eff = at_bottom ? 1'b1 : (at_top ? 1'b0 : count_up_reg);

	// each value, TOP included, stands for one tick; a TOP lowered
	// under the count runs on up through wrap until it meets TOP again
	always_ff @(posedge i_core_clk or negedge rst_b) begin
		if (!rst_b) begin
			count_value_reg <= CNT_RESET;
			count_up_reg <= 1'b1;
		end else if (wr_count) begin
			count_value_reg <= wr_merge_cnt[CNT_W-1:0];
		end else if (run_tick) begin
			count_up_reg <= dir_up_eff;
			if (dir_up_eff) begin
				count_value_reg <= count_value_reg + 16'h0001;
			end else begin
				count_value_reg <= count_value_reg - 16'h0001;
			end
		end
	end

	// phase correct reloads at TOP, so the next down slope still sees
	// the old TOP; frequency correct reloads at zero, slopes stay equal
	assign cnt_bus.tick = run_tick;
	assign cnt_bus.count = count_value_reg;
	assign cnt_bus.dir_up = dir_up_eff;
	assign cnt_bus.load_now = run_tick &&
		(is_pfc(waveform_select) ? at_bottom : at_top);

	// ----------------------------------------------------------------
	// compare channels
	// ----------------------------------------------------------------
	assign toggle_ok_a = (waveform_select == WGM_PFC_CMPA) ||
		(waveform_select == WGM_PC_CMPA);

	dsp_compare_unit u_cmp_a (
		.i_clk(i_core_clk),
		.i_rst_b(rst_b),
		.cnt(cnt_bus.sink),
		.i_action(output_action_select_a),
		.i_toggle_ok(toggle_ok_a),
		.i_buf_we(wr_cmp_a),
		.i_buf_data(wr_merge_a[CNT_W-1:0]),
		.o_buffer(cmp_a_buffer),
		.o_active(cmp_a_active),
		.o_match(match_a),
		.o_level(level_a)
	);

	dsp_compare_unit u_cmp_b (
		.i_clk(i_core_clk),
		.i_rst_b(rst_b),
		.cnt(cnt_bus.sink),
		.i_action(output_action_select_b),
		.i_toggle_ok(1'b0),
		.i_buf_we(wr_cmp_b),
		.i_buf_data(wr_merge_b[CNT_W-1:0]),
		.o_buffer(cmp_b_buffer),
		.o_active(cmp_b_active),
		.o_match(match_b),
		.o_level(level_b)
	);

	// ----------------------------------------------------------------
	// flags
	// ----------------------------------------------------------------
	// with compare A as TOP its match falls on the TOP tick by itself
	always_comb begin
		flag_set = '0;
		flag_set[FLG_OVF] = run_tick && at_bottom;
		flag_set[FLG_CMP_A] = match_a;
		flag_set[FLG_CMP_B] = match_b;
		flag_set[FLG_CAPT] = run_tick && at_top &&
			((waveform_select == WGM_PC_CAPT) ||
			(waveform_select == WGM_PFC_CAPT));
		flag_clr = (wr_flags && wstrb_reg[0]) ? wdata_reg[FLG_W-1:0] : '0;
	end

	// write one to clear; a set in the same cycle wins
	always_ff @(posedge i_core_clk or negedge rst_b) begin
		if (!rst_b) begin
			flags_reg <= '0;
		end else begin
			flags_reg <= (flags_reg & ~flag_clr) | flag_set;
		end
	end

	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	// toggle on B, or on A outside codes 9 and 11, leaves the pin alone
	assign conn_a = (output_action_select_a != ACT_OFF) &&
		((output_action_select_a != ACT_TOGGLE) || toggle_ok_a);
	assign conn_b = (output_action_select_b != ACT_OFF) &&
		(output_action_select_b != ACT_TOGGLE);

	// registered pins; driver enabled only by the direction bit
	always_ff @(posedge i_core_clk or negedge rst_b) begin
		if (!rst_b) begin
			o_pin_a <= 1'b0;
			o_pin_b <= 1'b0;
			o_pin_a_oe_b <= 1'b1;
			o_pin_b_oe_b <= 1'b1;
		end else begin
			o_pin_a <= conn_a ? level_a : i_port_data_a;
			o_pin_b <= conn_b ? level_b : i_port_data_b;
			o_pin_a_oe_b <= ~pin_direction_bit_a;
			o_pin_b_oe_b <= ~pin_direction_bit_b;
		end
	end

endmodule

// file: dsp_pkg.sv
// Contract
// - dual-slope modes count zero up to TOP, back to zero, forever
// - waveform codes 0x1, 0x2, 0x3 use fixed TOP 0x00ff, 0x01ff, 0x03ff
// - phase correct: code 0xa takes TOP from capture, 0xb from compare A
// - phase/frequency correct: code 0x8 TOP from capture, 0x9 from compare A
// - count holds TOP for one timer tick, then counts down
// - action 0x2 clears on up-match, sets on down-match; 0x3 inverse
// - a channel flag sets whenever count equals its compare value
// - phase correct sets overflow flag each time count reaches zero
// - phase correct loads compares at TOP; A or capture flag set then
// - TOP change: down slope keeps old length, up slope takes new
// - fixed TOP masks compare writes above active resolution to zero
// - phase correct: compare zero gives steady low, TOP steady high
// - code 0xb with A action 0x1 toggles output A, 50 percent duty
// - phase/frequency correct sets overflow when compares load at zero
// - phase/frequency correct sets A or capture flag at TOP
// - phase/frequency correct: compare zero steady low, TOP steady high
// - code 0x9 with A action 0x1 toggles output A, 50 percent duty
// - output reaches pin only when pin direction bit selects output
// - output period is 2*N*TOP clocks, N is 1, 8, 64, 256 or 1024
// - action 0x0 disconnects output, pin keeps ordinary port function
// - action 0x1 toggles A only for codes 9 or 11, else disconnected
package dsp_pkg;

	// ----------------------------------------------------------------
	// widths and register map
	// ----------------------------------------------------------------
	localparam int CNT_W = 16;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int PRE_W = 10;

	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_COUNT = 8'h04;
	localparam logic [ADDR_W-1:0] REG_CMP_A = 8'h08;
	localparam logic [ADDR_W-1:0] REG_CMP_B = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_CAPT = 8'h10;
	localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h14;

	// ----------------------------------------------------------------
	// control fields, reset values
	// ----------------------------------------------------------------
	localparam int CTRL_WGM_LSB = 0;
	localparam int CTRL_ACT_A_LSB = 4;
	localparam int CTRL_ACT_B_LSB = 6;
	localparam int CTRL_CS_LSB = 8;
	localparam int CTRL_DIR_A_BIT = 12;
	localparam int CTRL_DIR_B_BIT = 13;
	localparam logic [DATA_W-1:0] CTRL_MASK = 32'h0000_37ff;
	localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

	localparam int FLG_OVF = 0;
	localparam int FLG_CMP_A = 1;
	localparam int FLG_CMP_B = 2;
	localparam int FLG_CAPT = 3;
	localparam int FLG_W = 4;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// waveform codes, TOP values
	// ----------------------------------------------------------------
	localparam logic [3:0] WGM_PC8 = 4'h1;
	localparam logic [3:0] WGM_PC9 = 4'h2;
	localparam logic [3:0] WGM_PC10 = 4'h3;
	localparam logic [3:0] WGM_PFC_CAPT = 4'h8;
	localparam logic [3:0] WGM_PFC_CMPA = 4'h9;
	localparam logic [3:0] WGM_PC_CAPT = 4'ha;
	localparam logic [3:0] WGM_PC_CMPA = 4'hb;

	localparam logic [CNT_W-1:0] TOP_8 = 16'h00ff;
	localparam logic [CNT_W-1:0] TOP_9 = 16'h01ff;
	localparam logic [CNT_W-1:0] TOP_10 = 16'h03ff;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
	localparam logic [CNT_W-1:0] BOTTOM = 16'h0000;

	typedef enum logic [1:0] {
		ACT_OFF = 2'b00,
		ACT_TOGGLE = 2'b01,
		ACT_CLEAR_UP = 2'b10,
		ACT_SET_UP = 2'b11
	} dsp_action_type;

	// ----------------------------------------------------------------
	// prescaler selects and divide masks
	// ----------------------------------------------------------------
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [PRE_W-1:0] MASK_DIV1 = 10'h000;
	localparam logic [PRE_W-1:0] MASK_DIV8 = 10'h007;
	localparam logic [PRE_W-1:0] MASK_DIV64 = 10'h03f;
	localparam logic [PRE_W-1:0] MASK_DIV256 = 10'h0ff;
	localparam logic [PRE_W-1:0] MASK_DIV1024 = 10'h3ff;

	// mask of bits a compare may hold under a fixed TOP
	function automatic logic [CNT_W-1:0] fixed_mask(input logic [3:0] wgm);
		case (wgm)
			WGM_PC8: fixed_mask = TOP_8;
			WGM_PC9: fixed_mask = TOP_9;
			WGM_PC10: fixed_mask = TOP_10;
			default: fixed_mask = CNT_MAX;
		endcase
	endfunction

	// frequency correct modes load compares at bottom
	function automatic logic is_pfc(input logic [3:0] wgm);
		is_pfc = (wgm == WGM_PFC_CAPT) || (wgm == WGM_PFC_CMPA);
	endfunction

	function automatic logic is_dual(input logic [3:0] wgm);
		is_dual = is_pfc(wgm) || (wgm == WGM_PC8) || (wgm == WGM_PC9) ||
			(wgm == WGM_PC10) || (wgm == WGM_PC_CAPT) ||
			(wgm == WGM_PC_CMPA);
	endfunction

endpackage

// file: dsp_cnt_if.sv
`timescale 1ns/10ps
// counter state shared from the timebase to each compare unit
interface dsp_cnt_if;
	logic tick;
	logic [15:0] count;
	logic dir_up;
	logic load_now;

	modport source (output tick, count, dir_up, load_now);
	modport sink (input tick, count, dir_up, load_now);
endinterface

// file: dsp_prescaler.sv
`timescale 1ns/10ps
module dsp_prescaler (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// select and timer clock enable
	input wire logic [2:0] i_clk_sel,
	output logic o_tick
);
	import dsp_pkg::*;

	logic [PRE_W-1:0] pre_reg;
	logic [PRE_W-1:0] mask;

	// free-running divider; a stopped select still counts, harmless
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pre_reg <= 10'h000;
		end else begin
			pre_reg <= pre_reg + 10'h001;
		end
	end

	// one enable pulse every N clocks
	always_comb begin
		mask = MASK_DIV1;
		case (i_clk_sel)
			CS_DIV8: mask = MASK_DIV8;
			CS_DIV64: mask = MASK_DIV64;
			CS_DIV256: mask = MASK_DIV256;
			CS_DIV1024: mask = MASK_DIV1024;
			default: mask = MASK_DIV1;
		endcase
		o_tick = (i_clk_sel != CS_STOP) && ((pre_reg & mask) == mask);
	end
endmodule

// file: dsp_compare_unit.sv
`timescale 1ns/10ps
module dsp_compare_unit (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// counter state
	dsp_cnt_if.sink cnt,
	// configuration
	input wire dsp_pkg::dsp_action_type i_action,
	input wire logic i_toggle_ok,
	// buffer write
	input wire logic i_buf_we,
	input wire logic [15:0] i_buf_data,
	// state out
	output logic [15:0] o_buffer,
	output logic [15:0] o_active,
	output logic o_match,
	output logic o_level
);
	import dsp_pkg::*;

	// match is judged against the value in force before any reload
	assign o_match = cnt.tick && (cnt.count == o_active);

	// software only ever touches the buffer
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_buffer <= CNT_RESET;
		end else if (i_buf_we) begin
			o_buffer <= i_buf_data;
		end
	end

	// double buffer: reload at TOP or bottom as the timebase says
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_active <= CNT_RESET;
		end else if (cnt.load_now) begin
			o_active <= o_buffer;
		end
	end

	// waveform level; at TOP direction reads as down, at zero as up,
	// so extreme compares give steady levels
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_level <= 1'b0;
		end else if (o_match) begin
			case (i_action)
				ACT_TOGGLE: begin
					if (i_toggle_ok) begin
						o_level <= ~o_level;
					end
				end
				ACT_CLEAR_UP: o_level <= ~cnt.dir_up;
				ACT_SET_UP: o_level <= cnt.dir_up;
				ACT_OFF: o_level <= o_level;
			endcase
		end
	end
endmodule

// file: dsp_timer_chk.sv
`timescale 1ns/10ps
module dsp_timer_chk (
	// watched bus and pin ports
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic [1:0] o_bresp,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic o_rvalid,
	input wire logic i_rready,
	input wire logic [31:0] o_rdata,
	input wire logic o_pin_a_oe_b
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	// both write channels taken, or the read address taken
	sequence s_wr;
		i_awvalid && o_awready && i_wvalid && o_wready;
	endsequence
	sequence s_rd;
		i_arvalid && o_arready;
	endsequence
	AST_B_SOON: assert property (s_wr |-> ##[1:2] o_bvalid)
		else $error("write unanswered");
	AST_R_SOON: assert property (s_rd |=> o_rvalid)
		else $error("read unanswered");
	AST_B_HOLD: assert property (o_bvalid && !i_bready |=>
		o_bvalid && $stable(o_bresp)) else $error("write answer dropped");
	AST_R_HOLD: assert property (o_rvalid && !i_rready |=>
		o_rvalid && $stable(o_rdata)) else $error("read answer dropped");
	AST_AW_BUSY: assert property (o_bvalid |-> !o_awready && !o_wready)
		else $error("write ready while answering");
	AST_AR_BUSY: assert property (o_rvalid |-> !o_arready)
		else $error("read ready while answering");
	AST_B_DONE: assert property (o_bvalid && i_bready |=>
		!o_bvalid && o_awready) else $error("write not closed");
	AST_R_DONE: assert property (o_rvalid && i_rready |=>
		!o_rvalid && o_arready) else $error("read not closed");
	// drive enable only moves just after a control write lands
	AST_OE: assert property ($changed(o_pin_a_oe_b) |-> $past(o_bvalid))
		else $error("drive enable moved alone");
endmodule

// file: dsp_pin_load.sv
`timescale 1ns/10ps
module dsp_pin_load (
	// pin side
	input wire logic i_clk,
	input wire logic i_pin,
	input wire logic i_oe_b,
	// measurement
	input wire logic i_clr,
	output logic o_level,
	output int o_high,
	output int o_rise
);
	logic last_reg = 1'b0;
	// an undriven pin has no pull, so it must not look settled
	assign o_level = i_oe_b ? ~last_reg : i_pin;
	// high time and rising edges since the last clear
	always @(posedge i_clk) begin
		last_reg <= o_level;
		o_high <= i_clr ? 0 : o_high + int'(o_level);
		o_rise <= i_clr ? 0 : o_rise + int'(o_level && !last_reg);
	end
endmodule

// file: dsp_timer_tb.sv
`timescale 1ns/10ps
module dsp_timer_tb;
	import dsp_pkg::*;
	logic i_core_clk = 1'b0, i_rst_b = 1'b0, clr = 1'b0;
	logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
	logic i_arvalid = 1'b0, i_rready = 1'b0;
	logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic [2:0] i_awprot = 3'h0, i_arprot = 3'h0;
	logic [3:0] i_wstrb = 4'hf;
	logic i_port_data_a = 1'b0, i_port_data_b = 1'b0;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic o_pin_a, o_pin_a_oe_b, o_pin_b, o_pin_b_oe_b;
	logic [1:0] o_bresp, o_rresp;
	logic [31:0] o_rdata;
	logic [33:0] q[$];
	logic [33:0] e;
	logic [15:0] r;
	int error_cnt = 0, compares = 0, hi_n, ed_n;
	logic [15:0] tops[3] = '{TOP_8, TOP_9, TOP_10};
	// action, compare, high cycles and rising edges per 100 cycles
	int cs[4][4] = '{'{2,2,40,10},'{3,2,60,10},'{2,0,0,0},'{2,5,100,0}};
	logic [3:0] md[2] = '{WGM_PC_CAPT, WGM_PFC_CAPT};
	logic [3:0] tg[2] = '{WGM_PC_CMPA, WGM_PFC_CMPA};

	always #5 i_core_clk = ~i_core_clk;
	dsp_timer dsp_timer_i (.*);
	dsp_pin_load dsp_pin_load_i (.i_clk(i_core_clk), .i_pin(o_pin_a),
		.i_oe_b(o_pin_a_oe_b), .i_clr(clr), .o_level(),
		.o_high(hi_n), .o_rise(ed_n));

	task automatic check(input string nm, input logic [33:0] s,
		input logic [33:0] x);
		compares++;
		if (s !== x) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tmo();
		error_cnt++;
		final_report();
	endtask
	// hold each channel until its own ready, answer closes the write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic [1:0] x;
		@(posedge i_core_clk);
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_awaddr <= a;
		i_wdata <= d;
		i_bready <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge i_core_clk);
			if (i_awvalid && o_awready) i_awvalid <= 1'b0;
			if (i_wvalid && o_wready) i_wvalid <= 1'b0;
			if (o_bvalid === 1'b1) break;
		end
		i_bready <= 1'b0;
		if (n == 99) tmo();
		// only the mapped words answer okay
		x = (a > REG_FLAGS) ? RESP_SLVERR : RESP_OKAY;
		check("bresp", 34'(o_bresp), 34'(x));
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] x);
		int n;
		@(posedge i_core_clk);
		q.push_back(x);
		i_arvalid <= 1'b1;
		i_araddr <= a;
		i_rready <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge i_core_clk);
			if (i_arvalid && o_arready) i_arvalid <= 1'b0;
			if (o_rvalid === 1'b1) break;
		end
		i_rready <= 1'b0;
		if (n == 99) tmo();
	endtask
	// settle, then count over ten whole periods of a TOP of 5
	task automatic meas(input int h, input int n);
		repeat (60) @(posedge i_core_clk);
		clr <= 1'b1;
		@(posedge i_core_clk);
		clr <= 1'b0;
		repeat (100) @(posedge i_core_clk);
		#1;
		check("high", 34'(hi_n), 34'(h));
		check("edges", 34'(ed_n), 34'(n));
		$display("pin test done");
	endtask
	// oldest expected answer against each read that completes
	always @(posedge i_core_clk) begin
		if (o_rvalid === 1'b1 && i_rready === 1'b1) begin
			e = q.pop_front();
			check("read", {o_rresp, o_rdata}, e);
		end
	end

	initial begin
		void'($urandom(32'h00ca));
		repeat (8) @(posedge i_core_clk);
		i_rst_b <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		rd(REG_CTRL, 34'h0);
		rd(8'h20, {RESP_SLVERR, 32'h0});
		wr(8'h20, 32'h0);
		for (int i = 0; i < 3; i++) begin
			r = 16'($urandom);
			wr(REG_CTRL, 32'(i + 1));
			wr(REG_CMP_A, {16'h0, r});
			rd(REG_CMP_A, {18'h0, r & tops[i]});
		end
		wr(REG_COUNT, 32'h3);
		repeat (20) @(posedge i_core_clk);
		rd(REG_COUNT, 34'h3);
		$display("register test done");
		// TOP of 5 is fixed before the run and sits at or above every compare
		wr(REG_CAPT, 32'h5);
		for (int m = 0; m < 2; m++) begin
			for (int k = 0; k < 4; k++) begin
				wr(REG_CMP_A, 32'(cs[k][1]));
				wr(REG_CTRL, 32'h1100 | 32'(cs[k][0] << 4) | 32'(md[m]));
				meas(cs[k][2], cs[k][3]);
			end
			wr(REG_CTRL, 32'h1110 | 32'(tg[m]));
			meas(50, 5);
		end
		wr(REG_CMP_A, 32'h2);
		wr(REG_CTRL, 32'h1120 | 32'(WGM_PC_CAPT));
		wr(REG_FLAGS, 32'hf);
		repeat (30) @(posedge i_core_clk);
		rd(REG_FLAGS, 34'hf);
		for (int k = 0; k < 2; k++) begin
			i_port_data_a <= 1'($urandom);
			i_port_data_b <= 1'($urandom);
			wr(REG_CTRL, 32'h1100 | 32'((k << 4) | (k << 6)) |
				32'(WGM_PC_CAPT));
			repeat (4) @(posedge i_core_clk);
			check("port", 34'(o_pin_a), 34'(i_port_data_a));
			check("port b", 34'(o_pin_b), 34'(i_port_data_b));
		end
		wr(REG_CTRL, 32'h2120);
		repeat (4) @(posedge i_core_clk);
		check("drive", 34'(o_pin_a_oe_b), 34'h1);
		check("drive b", 34'(o_pin_b_oe_b), 34'h0);
		// halted mode raises no events, so a clear must stick
		wr(REG_FLAGS, 32'hf);
		rd(REG_FLAGS, 34'h0);
		$display("pin port test done");
		final_report();
	end
endmodule
bind dsp_timer dsp_timer_chk dsp_timer_chk_i (.*);
